// File: src/cgt_pkg.sv
`default_nettype none
package cgt_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL0    = 8'h00;
  localparam logic [7:0] OFS_CTRL1    = 8'h04;
  localparam logic [7:0] OFS_COUNT_HI = 8'h08;
  localparam logic [7:0] OFS_COUNT_LO = 8'h0C;
  localparam logic [7:0] OFS_RELOAD   = 8'h10;
  localparam logic [7:0] OFS_CAPTURE  = 8'h14;
  localparam logic [7:0] OFS_OUTCFG   = 8'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned C0_MODE_TOP = 7;
  localparam int unsigned C0_ISS_LSB  = 5;
  localparam int unsigned C0_CAPFLAG  = 0;
  localparam int unsigned C1_ENABLE   = 7;
  localparam int unsigned C1_POL      = 6;
  localparam int unsigned C1_PRESCALE_SELECT_LSB = 3;
  localparam int unsigned C1_MODE_LSB = 0;
  localparam int unsigned OC_OUT_FN   = 0;

  // ---------------------------------------------------------------
  // Reset, restart and step values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_COUNT   = 16'h0000;
  localparam logic [15:0] RST_RELOAD  = 16'h0000;
  localparam logic [15:0] RST_CAPTURE = 16'h0000;
  localparam logic [15:0] RESTART_VAL = 16'h0001;
  localparam logic [15:0] STEP        = 16'h0001;

  // ---------------------------------------------------------------
  // Modes {mode_select_top, mode_select_low}
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_CAP_RESTART = 4'h8;
  localparam logic [3:0] MODE_COMPARE     = 4'h5;
  localparam logic [3:0] MODE_GATED       = 4'h6;
  localparam logic [3:0] MODE_CAP_CMP     = 4'h7;
  localparam logic [3:0] MODE_DUAL_PWM    = 4'h9;

  // ---------------------------------------------------------------
  // Interrupt source select codes
  // ---------------------------------------------------------------
  localparam logic [1:0] ISS_INPUT_ONLY  = 2'h2;
  localparam logic [1:0] ISS_RELOAD_ONLY = 2'h3;

  localparam int unsigned PRESCALE_SELECT_W = 3;
  localparam int unsigned DIV_W  = 7;

  typedef enum logic [0:0] {
    RUN_WAIT = 1'b0,
    RUN_GO   = 1'b1
  } cgt_run_e;

endpackage
`default_nettype wire

// File: src/cgt_prescaler.sv
`default_nettype none
module cgt_prescaler
  import cgt_pkg::*;
#(
  parameter int unsigned DIV_BITS = cgt_pkg::DIV_W
) (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // Control
  input  wire logic                          clear,
  input  wire logic [cgt_pkg::PRESCALE_SELECT_W-1:0]    sel,
  // Count enable
  output logic                               tick
);
  import cgt_pkg::*;

  typedef struct packed {
    logic [DIV_BITS-1:0] cnt;
    logic                tick;
  } cgt_div_s;

  cgt_div_s s_r;
  cgt_div_s s_nxt;
  logic [DIV_BITS-1:0] mask;

  always_comb begin
    mask = DIV_BITS'((32'h1 << sel) - 32'h1);
    s_nxt = s_r;
    // Cleared while disabled so each restart divides from a clean phase
    if (clear) begin
      s_nxt.cnt  = '0;
      s_nxt.tick = 1'b0;
    end else begin
      s_nxt.cnt  = DIV_BITS'(s_r.cnt + 1'b1);
      s_nxt.tick = ((s_r.cnt & mask) == mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

endmodule
`default_nettype wire

// File: src/cgt_timer.sv
`default_nettype none
module cgt_timer
  import cgt_pkg::*;
(
  // APB clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [cgt_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [cgt_pkg::DATA_W-1:0]    pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [cgt_pkg::DATA_W-1:0]    prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Timer pins
  input  wire logic                          timer_in,
  output logic                               timer_in_en,
  output logic                               timer_out,
  output logic                               timer_out_en,
  // Timer interrupt request
  output logic                               timer_irq
);
  import cgt_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                sync1;
    logic                sync2;
    logic                tin_prev;
    logic                enable;
    logic                pol;
    logic [PRESCALE_SELECT_W-1:0]   prescale_select;
    logic [3:0]          mode;
    logic [1:0]          iss;
    logic                out_fn;
    logic [15:0]         count;
    logic [15:0]         reload;
    logic [15:0]         capture;
    logic [7:0]          hold;
    logic                capflag;
    cgt_run_e            run;
    logic                irq;
    logic                tout;
    logic                tin_en;
    logic                pready;
    logic                pslverr;
    logic [DATA_W-1:0]   prdata;
  } cgt_st_s;

  cgt_st_s s_r;
  cgt_st_s s_nxt;
  logic    tick;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [DATA_W-1:0] wd,
                                          input logic [3:0] st);
    logic [15:0] r;
    r = old_v;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_CTRL0) || (a == OFS_CTRL1) || (a == OFS_COUNT_HI) ||
           (a == OFS_COUNT_LO) || (a == OFS_RELOAD) || (a == OFS_CAPTURE) ||
           (a == OFS_OUTCFG);
  endfunction

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  cgt_prescaler #(
    .DIV_BITS (DIV_W)
  ) u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (!s_r.enable),
    .sel     (s_r.prescale_select),
    .tick    (tick)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic lvl;
  logic lvl_q;
  logic act;
  logic act_q;
  logic sel_edge;
  logic deassert;
  logic match;
  logic in_ev;
  logic rl_ev;
  logic cap_ev;
  logic clr_ev;
  logic acc;
  logic setup;
  logic wr;
  logic rd;

  always_comb begin
    s_nxt = s_r;
    in_ev  = 1'b0;
    rl_ev  = 1'b0;
    cap_ev = 1'b0;
    clr_ev = 1'b0;

    // Only the second and third stages are looked at; the first may be metastable
    s_nxt.sync1    = timer_in;
    s_nxt.sync2    = s_r.sync1;
    s_nxt.tin_prev = s_r.sync2;

    // Without the input function the pin reads as permanently inactive
    lvl   = s_r.tin_en ? s_r.sync2 : s_r.pol;
    lvl_q = s_r.tin_en ? s_r.tin_prev : s_r.pol;
    act   = lvl ^ s_r.pol;
    act_q = lvl_q ^ s_r.pol;
    sel_edge = act & !act_q;
    deassert = !act & act_q;
    match    = (s_r.count == s_r.reload);

    s_nxt.tin_en = ({s_r.mode} != MODE_DUAL_PWM);

    if (!s_r.enable) begin
      s_nxt.tout = s_r.pol;
      s_nxt.run  = RUN_WAIT;
    end else begin
      case (s_r.mode)
        MODE_CAP_RESTART: begin
          if (sel_edge) begin
            s_nxt.capture = s_r.count;
            s_nxt.count   = RESTART_VAL;
            in_ev  = 1'b1;
            cap_ev = 1'b1;
          end else if (tick && match) begin
            s_nxt.count = RESTART_VAL;
            rl_ev  = 1'b1;
            clr_ev = 1'b1;
          end else if (tick) begin
            s_nxt.count = 16'(s_r.count + STEP);
          end
        end
        MODE_COMPARE: begin
          // Counts on the prescaler only; the pin never clocks it
          if (tick) begin
            if (match) begin
              rl_ev = 1'b1;
              s_nxt.tout = !s_r.tout;
            end
            s_nxt.count = 16'(s_r.count + STEP);
          end
        end
        MODE_GATED: begin
          if (deassert) begin
            in_ev = 1'b1;
          end
          if (tick && act) begin
            if (match) begin
              // Restart value is fixed, so a written start only lasts one pass
              s_nxt.count = RESTART_VAL;
              rl_ev = 1'b1;
              s_nxt.tout = !s_r.tout;
            end else begin
              s_nxt.count = 16'(s_r.count + STEP);
            end
          end
        end
        MODE_CAP_CMP: begin
          if (s_r.run == RUN_WAIT) begin
            if (sel_edge) begin
              s_nxt.run = RUN_GO;
            end
          end else if (sel_edge) begin
            s_nxt.capture = s_r.count;
            s_nxt.count   = RESTART_VAL;
            in_ev  = 1'b1;
            cap_ev = 1'b1;
          end else if (tick && match) begin
            s_nxt.count = RESTART_VAL;
            rl_ev  = 1'b1;
            clr_ev = 1'b1;
          end else if (tick) begin
            s_nxt.count = 16'(s_r.count + STEP);
          end
        end
        default: begin
        end
      endcase
    end

    // Set takes priority should both ever coincide
    if (cap_ev) begin
      s_nxt.capflag = 1'b1;
    end else if (clr_ev) begin
      s_nxt.capflag = 1'b0;
    end

    s_nxt.irq = (in_ev && (s_r.iss != ISS_RELOAD_ONLY)) ||
                (rl_ev && (s_r.iss != ISS_INPUT_ONLY));

    // ---------------------------------------------------------------
    // APB: one wait state, then the transfer completes
    // ---------------------------------------------------------------
    setup = psel && penable && !s_r.pready;
    acc   = psel && penable && s_r.pready;
    wr    = acc && pwrite && mapped(paddr);
    rd    = setup && !pwrite;
    s_nxt.pready = setup;
    if (setup) begin
      s_nxt.pslverr = !mapped(paddr);
      s_nxt.prdata  = '0;
      if (!pwrite) begin
        case (paddr)
          OFS_CTRL0: begin
            s_nxt.prdata[C0_MODE_TOP] = s_r.mode[3];
            s_nxt.prdata[C0_ISS_LSB +: 2] = s_r.iss;
            s_nxt.prdata[C0_CAPFLAG] = s_r.capflag;
          end
          OFS_CTRL1: begin
            s_nxt.prdata[C1_ENABLE] = s_r.enable;
            s_nxt.prdata[C1_POL] = s_r.pol;
            s_nxt.prdata[C1_PRESCALE_SELECT_LSB +: PRESCALE_SELECT_W] = s_r.prescale_select;
            s_nxt.prdata[C1_MODE_LSB +: 3] = s_r.mode[2:0];
          end
          OFS_COUNT_HI: s_nxt.prdata[7:0] = s_r.count[15:8];
          OFS_COUNT_LO: begin
            s_nxt.prdata[7:0] = s_r.enable ? s_r.hold : s_r.count[7:0];
          end
          OFS_RELOAD:  s_nxt.prdata[15:0] = s_r.reload;
          OFS_CAPTURE: s_nxt.prdata[15:0] = s_r.capture;
          OFS_OUTCFG:  s_nxt.prdata[OC_OUT_FN] = s_r.out_fn;
          default: begin
          end
        endcase
      end
    end else if (acc) begin
      s_nxt.pslverr = 1'b0;
    end

    // Latch on the edge that samples the high byte, so both halves match
    if (rd && (paddr == OFS_COUNT_HI) && s_r.enable) begin
      s_nxt.hold = s_r.count[7:0];
    end

    // Software writes land last and override the timer's own update
    if (wr && pstrb[0]) begin
      case (paddr)
        OFS_CTRL0: begin
          s_nxt.mode[3] = pwdata[C0_MODE_TOP];
          s_nxt.iss     = pwdata[C0_ISS_LSB +: 2];
        end
        OFS_CTRL1: begin
          s_nxt.enable    = pwdata[C1_ENABLE];
          s_nxt.pol       = pwdata[C1_POL];
          s_nxt.prescale_select      = pwdata[C1_PRESCALE_SELECT_LSB +: PRESCALE_SELECT_W];
          s_nxt.mode[2:0] = pwdata[C1_MODE_LSB +: 3];
        end
        OFS_COUNT_HI: s_nxt.count[15:8] = pwdata[7:0];
        OFS_COUNT_LO: s_nxt.count[7:0]  = pwdata[7:0];
        OFS_OUTCFG:   s_nxt.out_fn      = pwdata[OC_OUT_FN];
        default: begin
        end
      endcase
    end
    if (wr && (paddr == OFS_RELOAD)) begin
      s_nxt.reload = merge16(s_r.reload, pwdata, pstrb);
    end
    if (wr && (paddr == OFS_CAPTURE)) begin
      // Clearing this before enabling lets software spot reload interrupts
      s_nxt.capture = merge16(s_r.capture, pwdata, pstrb);
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r         <= '0;
      s_r.count   <= RST_COUNT;
      s_r.reload  <= RST_RELOAD;
      s_r.capture <= RST_CAPTURE;
      s_r.run     <= RUN_WAIT;
      s_r.tin_en  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata       = s_r.prdata;
  assign pready       = s_r.pready;
  assign pslverr      = s_r.pslverr;
  assign timer_in_en  = s_r.tin_en;
  assign timer_out    = s_r.tout;
  assign timer_out_en = s_r.out_fn;
  assign timer_irq    = s_r.irq;

endmodule
`default_nettype wire

// File: verif/cgt_pin_model.sv
`default_nettype none
module cgt_pin_model (
  // Clock
  input  wire logic pclk,
  // Wanted level and pin direction
  input  wire logic lvl,
  input  wire logic timer_in_en,
  // Pin
  output var  logic timer_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial timer_in = 1'b0;
  // Pin turns into an output in dual PWM; a changing pattern stops a stale level passing
  always @(posedge pclk) timer_in <= timer_in_en ? lvl : ~timer_in;
endmodule
`default_nettype wire

// File: verif/cgt_tb_top.sv
`default_nettype none
module capture_compare_gated_timer_tb_top
  import cgt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lvl = 0, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, r, seed = 32'h9338B6D2;
  logic pready, pslverr, timer_in, timer_in_en, timer_out, timer_out_en, timer_irq;
  int fail_count = 0, checked = 0;
  always #4 pclk = ~pclk;
  cgt_timer i_cgt_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hF), .prdata, .pready, .pslverr, .timer_in, .timer_in_en, .timer_out,
    .timer_out_en, .timer_irq);
  cgt_pin_model i_cgt_pin_model (.pclk, .lvl, .timer_in_en, .timer_in);
  // ----
  // Expectations and helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] rnd_rl(input logic [31:0] base);
    seed = lfsr(seed);
    return base + {26'h0, seed[5:0]};
  endfunction
  function automatic logic [31:0] c0(input logic [3:0] m, input logic [1:0] s, input logic f);
    return {24'h0, m[3], s, 4'h0, f};
  endfunction
  function automatic logic [31:0] c1(input logic e, input logic p, input logic [3:0] m);
    return {24'h0, e, p, 3'h0, m[2:0]};
  endfunction
  function automatic logic [31:0] in_rng(input logic [31:0] v, input logic [31:0] lo, hi);
    return {31'h0, v >= lo && v <= hi};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      tally_and_finish();
    end
    // Completing edge: take the answer here and release at once
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    chk(rd, exp);
  endtask
  task automatic cfg(input logic [3:0] m, input logic p, input logic [1:0] s, input logic e);
    apb(1, OFS_CTRL0, c0(m, s, 0));
    apb(1, OFS_CTRL1, c1(e, p, m));
  endtask
  task automatic setup(input logic [3:0] m, input logic p, input logic [1:0] s,
                       input logic [31:0] rl, input logic oc);
    cfg(m, p, s, 0);
    apb(1, OFS_COUNT_HI, 0);
    apb(1, OFS_COUNT_LO, 0);
    apb(1, OFS_CAPTURE, 0);
    apb(1, OFS_RELOAD, rl);
    apb(1, OFS_OUTCFG, {31'h0, oc});
    cfg(m, p, s, 1);
  endtask
  task automatic pin(input logic v, input int hold);
    @(posedge pclk);
    lvl <= v;
    repeat (hold) @(posedge pclk);
  endtask
  task automatic irq_chk(input int lim, input logic exp);
    logic g;
    g = 1'b0;
    for (int i = 0; i < lim && !g; i++) begin
      @(negedge pclk);
      g = timer_irq === 1'b1;
    end
    chk({31'h0, g}, {31'h0, exp});
    if (exp && !g) tally_and_finish();
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    for (int a = 0; a <= 8'h18; a += 4) rdc(8'(a), 0);
    apb(0, 8'h40, 0);
    chk({31'h0, err}, 1);
    for (int p = 0; p < 2; p++) begin
      pin(p, 8);
      setup(MODE_CAP_RESTART, p, 2'h0, 16'hFFFF, 0);
      pin(p, 20);
      pin(!p, 0);
      irq_chk(12, 1);
      rdc(OFS_CTRL0, c0(MODE_CAP_RESTART, 2'h0, 1));
      apb(0, OFS_CAPTURE, 0);
      chk(in_rng(rd, 16, 40), 1);
      rdc(OFS_COUNT_HI, 0);
      apb(0, OFS_COUNT_LO, 0);
      chk(in_rng(rd, 1, 32), 1);
      pin(p, 0);
      irq_chk(20, 0);
    end
    r = rnd_rl(16);
    setup(MODE_CAP_RESTART, 1, 2'h0, r, 0);
    irq_chk(r + 12, 1);
    rdc(OFS_CTRL0, c0(MODE_CAP_RESTART, 2'h0, 0));
    rdc(OFS_CAPTURE, 0);
    irq_chk(r + 4, 1);
    cfg(MODE_CAP_RESTART, 1, ISS_RELOAD_ONLY, 1);
    pin(0, 5);
    irq_chk(8, 0);
    rdc(OFS_CTRL0, c0(MODE_CAP_RESTART, ISS_RELOAD_ONLY, 1));
    r = rnd_rl(16);
    setup(MODE_COMPARE, 0, 2'h0, r, 1);
    irq_chk(r + 12, 1);
    repeat (3) @(negedge pclk);
    chk({31'h0, timer_out}, 1);
    chk({31'h0, timer_out_en}, 1);
    irq_chk(r + 12, 0);
    cfg(MODE_COMPARE, 0, 2'h0, 0);
    apb(0, OFS_COUNT_LO, 0);
    chk(in_rng(rd, r + 1, 255), 1);
    setup(MODE_COMPARE, 0, ISS_INPUT_ONLY, r, 1);
    irq_chk(r + 12, 0);
    cfg(MODE_COMPARE, 0, 2'h0, 0);
    apb(1, OFS_COUNT_HI, 0);
    apb(1, OFS_COUNT_LO, 0);
    // Divide by 8: the match must come near eight times later
    apb(1, OFS_CTRL1, c1(1, 0, MODE_COMPARE) | 32'h18);
    irq_chk(r + 12, 0);
    irq_chk(7 * r + 20, 1);
    for (int p = 0; p < 2; p++) begin
      r = rnd_rl(16);
      pin(p, 4);
      setup(MODE_GATED, p, 2'h0, r, 1);
      irq_chk(30, 0);
      rdc(OFS_COUNT_HI, 0);
      rdc(OFS_COUNT_LO, 0);
      pin(!p, 0);
      irq_chk(r + 12, 1);
      repeat (2) @(negedge pclk);
      chk({31'h0, timer_out}, {31'h0, !p});
      irq_chk(r + 4, 1);
      pin(p, 0);
      irq_chk(10, 1);
    end
    pin(1, 4);
    setup(MODE_CAP_CMP, 1, 2'h0, 16'hFFFF, 0);
    irq_chk(20, 0);
    rdc(OFS_COUNT_HI, 0);
    rdc(OFS_COUNT_LO, 0);
    pin(0, 0);
    irq_chk(12, 0);
    pin(1, 30);
    pin(0, 0);
    irq_chk(12, 1);
    rdc(OFS_CTRL0, c0(MODE_CAP_CMP, 2'h0, 1));
    apb(0, OFS_CAPTURE, 0);
    chk(in_rng(rd, 24, 48), 1);
    r = rnd_rl(80);
    apb(1, OFS_RELOAD, r);
    irq_chk(r + 12, 1);
    rdc(OFS_CTRL0, c0(MODE_CAP_CMP, 2'h0, 0));
    cfg(MODE_DUAL_PWM, 0, 2'h0, 1);
    repeat (4) @(negedge pclk);
    chk({31'h0, timer_in_en}, 0);
    cfg(MODE_COMPARE, 0, 2'h0, 0);
    repeat (4) @(negedge pclk);
    chk({31'h0, timer_in_en}, 1);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// File: verif/cgt_timer_properties.sv
`default_nettype none
module cgt_timer_chk
  import cgt_pkg::*;
(
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Timer pins
  input wire logic              timer_in,
  input wire logic              timer_in_en,
  input wire logic              timer_out,
  input wire logic              timer_out_en,
  input wire logic              timer_irq
);
  // ----
  // Shadow of the configuration
  // ----
  logic [7:0] c0_r;
  logic [7:0] c1_r;
  logic       oc_r;
  logic [1:0] cnt_r;
  logic       wr;
  logic       quiet;
  logic [3:0] mode;
  assign wr = psel && penable && pready && pwrite;
  assign mode = {c0_r[7], c1_r[2:0]};
  // Outputs are registered behind the config, so judge them only once it has settled
  assign quiet = cnt_r == 2'h3;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0_r <= 8'h00;
      c1_r <= 8'h00;
      oc_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (wr && paddr == OFS_CTRL0) c0_r <= pwdata[7:0];
      if (wr && paddr == OFS_CTRL1) c1_r <= pwdata[7:0];
      if (wr && paddr == OFS_OUTCFG) oc_r <= pwdata[0];
      if (wr && (paddr == OFS_CTRL0 || paddr == OFS_CTRL1 || paddr == OFS_OUTCFG)) cnt_r <= 2'h0;
      else if (!quiet) cnt_r <= cnt_r + 2'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_apb_wait;
    psel && penable && !$past(penable) |-> !pready ##1 pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready not after one wait state");
  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");
  property p_err_qual;
    pslverr |-> pready && prdata == '0;
  endproperty
  a_err_qual: assert property (p_err_qual) else $error("pslverr without pready or zero data");
  property p_in_en;
    quiet |-> timer_in_en == (mode != MODE_DUAL_PWM);
  endproperty
  a_in_en: assert property (p_in_en) else $error("timer input enable wrong");
  property p_idle_quiet;
    quiet && !c1_r[7] |-> !timer_irq;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("interrupt while disabled");
  property p_idle_out;
    quiet && !c1_r[7] |-> timer_out == c1_r[6];
  endproperty
  a_idle_out: assert property (p_idle_out) else $error("idle output not polarity");
  property p_out_en;
    quiet |-> timer_out_en == oc_r;
  endproperty
  a_out_en: assert property (p_out_en) else $error("output enable wrong");
  property p_iss_cmp;
    quiet && c1_r[7] && mode == MODE_COMPARE && c0_r[6:5] == ISS_INPUT_ONLY |-> !timer_irq;
  endproperty
  a_iss_cmp: assert property (p_iss_cmp) else $error("compare irq not masked");
endmodule
bind cgt_timer cgt_timer_chk i_cgt_timer_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .timer_in, .timer_in_en,
  .timer_out, .timer_out_en, .timer_irq);
`default_nettype wire
